// >>> rtl/pin_ctrl_pkg.sv
/*
  constants for the host-side pin and mode controller of a power management chip.
  assumes a 50 MHz core clock and a host that drives the register port described in main file.
*/
package pin_ctrl_pkg;
  localparam logic [3:0] ADDR_MODE   = 4'h0;
  localparam logic [3:0] ADDR_PINS   = 4'h1;
  localparam logic [3:0] ADDR_COMM   = 4'h2;
  localparam logic [3:0] ADDR_PULSE  = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DIV    = 4'h5;

  // pin bit positions in the pin register
  localparam int PIN_DEBUG = 0;
  localparam int PIN_STBY  = 1;
  localparam int PIN_WDOG  = 2;
  localparam int PIN_POWER_ON_PIN = 3;
  localparam int PIN_AUXEN = 4;
  localparam int PIN_XINT  = 5;
  localparam int PIN_VSEL  = 6;
  localparam int NUM_PINS  = 7;

  // comm register fields
  localparam int COMM_ADDR_LSB = 0;
  localparam int COMM_CRC      = 7;
  localparam int COMM_SECURE   = 8;
  localparam logic [6:0] I2C_ADDR_RESET = 7'h08;

  localparam logic [NUM_PINS-1:0] PINS_RESET = 7'h00;

  // edge pulse width on power-on pin at DIV 0, in ns, and its count of divider ticks
  localparam int CLK_PERIOD_NS   = 20;
  localparam int PULSE_WIDTH_NS  = 1000;
  localparam int PULSE_CYCLES    = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] DIV_RESET = 16'h0031;

  typedef enum logic [1:0] {
    MODE_USER   = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_TRIAL  = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_APPLY = 2'b01,
    ST_PULSE = 2'b10
  } state_t;
endpackage : pin_ctrl_pkg

// >>> rtl/tick_divider.sv
/*
  one-cycle enable pulse every DIV+1 clocks.
  assumes a synchronous reset copy from the top.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] div,
  output var  logic         tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_st_t;

  div_st_t s_q;
  div_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= div) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : tick_divider
`default_nettype wire

// >>> rtl/pin_mode_ctrl.sv
/*
  host-side controller driving the mode and control pins of a power management chip.
  software reaches it over a plain register port; read data appears one cycle after the strobe.
  the i2c engine lives elsewhere and reads address, crc and secure-write flags from this block.
*/
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pin_mode_ctrl
  import pin_ctrl_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [31:0] RDATA,
  output var  logic        OTP_DEBUG_ENABLE,
  output var  logic        STANDBY_PIN,
  output var  logic        WATCHDOG_INPUT_PIN,
  output var  logic        POWER_ON_PIN,
  output var  logic        AUX_REGULATOR_ENABLE_PIN,
  output var  logic        EXTERNAL_INTERRUPT_INPUT,
  output var  logic        OUTPUT_VOLTAGE_SELECT_PIN,
  output var  logic [6:0]  I2C_TARGET_ADDR,
  output var  logic        I2C_CRC_ENABLE,
  output var  logic        I2C_SECURE_WRITE,
  output var  logic        OTP_TRIAL_MODE,
  output var  logic        FUNC_REGS_ALLOWED
);
  logic [1:0] rst_sync_q;
  logic       rst_n_int;
  logic       tick;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_q[1];

  typedef struct packed {
    mode_t                mode;
    mode_t                req_mode;
    state_t               state;
    logic [NUM_PINS-1:0]  pins;
    logic [6:0]           i2c_addr;
    logic                 crc_en;
    logic                 secure_en;
    logic [15:0]          div;
    logic [15:0]          pulse_cnt;
    logic                 pulse_level;
    logic                 cmd_refused;
    logic [31:0]          rdata;
  } ctrl_st_t;

  ctrl_st_t s_q;
  ctrl_st_t s_d;

  tick_divider #(
    .W (16)
  ) u_div (
    .clk   (CORE_CLK),
    .rst_n (rst_n_int),
    .div   (s_q.div),
    .tick  (tick)
  );

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    case (s_q.state)
      ST_IDLE: begin
        if (WR) begin
          case (ADDR)
            ADDR_MODE: begin
              // bit 2 is apply; mode only changes with it
              if (WDATA[2]) begin
                s_d.req_mode = mode_t'(WDATA[1:0]);
                s_d.state    = ST_APPLY;
              end
            end
            ADDR_PINS: begin
              // manual pin commands; in user mode only these and pulse writes touch pins
              s_d.pins = WDATA[NUM_PINS-1:0];
            end
            ADDR_COMM: begin
              s_d.i2c_addr  = WDATA[COMM_ADDR_LSB +: 7];
              s_d.crc_en    = WDATA[COMM_CRC];
              s_d.secure_en = WDATA[COMM_SECURE];
            end
            ADDR_PULSE: begin
              // push-button style pulse on power-on pin; edges at start and end
              s_d.pulse_level     = WDATA[0];
              s_d.pins[PIN_POWER_ON_PIN] = WDATA[0];
              s_d.pulse_cnt       = '0;
              s_d.state           = ST_PULSE;
            end
            ADDR_DIV: begin
              s_d.div = WDATA[15:0];
            end
            default: begin
            end
          endcase
        end
      end
      ST_APPLY: begin
        // whole pattern driven in one cycle before pin commands resume
        s_d.mode  = s_q.req_mode;
        s_d.state = ST_IDLE;
        case (s_q.req_mode)
          MODE_NORMAL: begin
            s_d.pins[PIN_DEBUG] = 1'b0;
            s_d.pins[PIN_STBY]  = 1'b0;
            s_d.pins[PIN_WDOG]  = 1'b0;
            s_d.pins[PIN_POWER_ON_PIN] = 1'b1;
          end
          MODE_TRIAL: begin
            s_d.pins[PIN_DEBUG] = 1'b1;
            s_d.pins[PIN_STBY]  = 1'b0;
            s_d.pins[PIN_WDOG]  = 1'b0;
            s_d.pins[PIN_POWER_ON_PIN] = 1'b0;
          end
          default: begin
            s_d.mode = MODE_USER;
          end
        endcase
      end
      ST_PULSE: begin
        if (tick) begin
          s_d.pulse_cnt = s_q.pulse_cnt + 16'h0001;
          if (s_q.pulse_cnt >= 16'(PULSE_CYCLES - 1)) begin
            s_d.pins[PIN_POWER_ON_PIN] = ~s_q.pulse_level;
            s_d.state           = ST_IDLE;
          end
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
    // writes while busy are dropped and flagged
    if (WR && s_q.state != ST_IDLE) begin
      s_d.cmd_refused = 1'b1;
    end else if (WR && ADDR == ADDR_STATUS) begin
      s_d.cmd_refused = 1'b0;
    end
    if (RD) begin
      case (ADDR)
        ADDR_MODE:   s_d.rdata = {30'h0, s_q.mode};
        ADDR_PINS:   s_d.rdata = {25'h0, s_q.pins};
        ADDR_COMM:   s_d.rdata = {23'h0, s_q.secure_en, s_q.crc_en, s_q.i2c_addr};
        ADDR_STATUS: s_d.rdata = {27'h0, s_q.cmd_refused, (s_q.mode == MODE_TRIAL),
                                  s_q.state, (s_q.state != ST_IDLE)};
        ADDR_DIV:    s_d.rdata = {16'h0, s_q.div};
        default:     s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s_q             <= '0;
      s_q.mode        <= MODE_USER;
      s_q.req_mode    <= MODE_USER;
      s_q.state       <= ST_IDLE;
      s_q.pins        <= PINS_RESET;
      s_q.i2c_addr    <= I2C_ADDR_RESET;
      s_q.div         <= DIV_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  logic trial_q;
  logic func_q;
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      trial_q <= 1'b0;
      func_q  <= 1'b1;
    end else begin
      trial_q <= (s_d.mode == MODE_TRIAL);
      func_q  <= (s_d.mode != MODE_TRIAL);
    end
  end

  assign RDATA                     = s_q.rdata;
  assign OTP_DEBUG_ENABLE          = s_q.pins[PIN_DEBUG];
  assign STANDBY_PIN               = s_q.pins[PIN_STBY];
  assign WATCHDOG_INPUT_PIN        = s_q.pins[PIN_WDOG];
  assign POWER_ON_PIN              = s_q.pins[PIN_POWER_ON_PIN];
  assign AUX_REGULATOR_ENABLE_PIN  = s_q.pins[PIN_AUXEN];
  assign EXTERNAL_INTERRUPT_INPUT  = s_q.pins[PIN_XINT];
  assign OUTPUT_VOLTAGE_SELECT_PIN = s_q.pins[PIN_VSEL];
  assign I2C_TARGET_ADDR           = s_q.i2c_addr;
  assign I2C_CRC_ENABLE            = s_q.crc_en;
  assign I2C_SECURE_WRITE          = s_q.secure_en;
  assign OTP_TRIAL_MODE            = trial_q;
  assign FUNC_REGS_ALLOWED         = func_q;
endmodule : pin_mode_ctrl
`default_nettype wire

// >>> tb/pmic_model.sv
/* behavioural power chip facing the control pins; pins = {vsel,xint,aux,power_on_pin,wdog,stby,dbg}.
   assumes level-sensed power-on and pins that change just after rising clk edges. */
`timescale 1ns/1ps
`default_nettype none
module pmic_model #(
  parameter bit STBY_INV = 1'b0,
  parameter bit WDI_INV  = 1'b0
) (
  input  wire logic       clk,
  input  wire logic [6:0] pins,
  output var  logic       powered,
  output var  logic       quiet,
  output var  logic       mirrors_open,
  output var  int         presses,
  output var  logic       irq_seen,
  output var  int         wdog_events
);
  logic [6:0] prev = 7'h00;
  logic       in_stby, aux_on, sel_1v8;
  assign powered = pins[3];
  assign quiet = pins[0] & ~pins[3];
  assign mirrors_open = pins[0];
  assign in_stby = pins[1] ^ STBY_INV;
  assign aux_on = pins[4];
  assign sel_1v8 = pins[6];
  initial presses = 0;
  initial irq_seen = 1'b0;
  initial wdog_events = 0;
  always @(posedge clk) begin
    prev <= pins;
    if (pins[3] && !prev[3]) presses <= presses + 1;
    if (pins[5]) irq_seen <= 1'b1;
    if (pins[2] != prev[2] && pins[2] != WDI_INV) wdog_events <= wdog_events + 1;
  end
endmodule : pmic_model
`default_nettype wire

// >>> tb/pin_mode_ctrl_sva.sv
/* assertions on the ports of the pin and mode controller.
   assumes no register write while a power-on pulse is running. */
`timescale 1ns/1ps
`default_nettype none
module pin_mode_ctrl_sva
  import pin_ctrl_pkg::*;
(
  input wire logic        CORE_CLK, RST_N, WR, RD,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA, RDATA,
  input wire logic        OTP_DEBUG_ENABLE, STANDBY_PIN, WATCHDOG_INPUT_PIN, POWER_ON_PIN,
  input wire logic        AUX_REGULATOR_ENABLE_PIN, EXTERNAL_INTERRUPT_INPUT,
  input wire logic        OUTPUT_VOLTAGE_SELECT_PIN, I2C_CRC_ENABLE, I2C_SECURE_WRITE,
  input wire logic [6:0]  I2C_TARGET_ADDR,
  input wire logic        OTP_TRIAL_MODE, FUNC_REGS_ALLOWED
);
  wire logic [6:0] pv = {OUTPUT_VOLTAGE_SELECT_PIN, EXTERNAL_INTERRUPT_INPUT,
    AUX_REGULATOR_ENABLE_PIN, POWER_ON_PIN, WATCHDOG_INPUT_PIN, STANDBY_PIN, OTP_DEBUG_ENABLE};
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_apply(logic [1:0] m);
    WR && ADDR == ADDR_MODE && WDATA[2:0] == {1'b1, m};
  endsequence
  a_normal_pattern: assert property (
    s_apply(2'd1) |-> ##2 pv[3:0] == 4'h8 && FUNC_REGS_ALLOWED)
    else $error("normal pattern wrong");
  a_trial_pattern: assert property (
    s_apply(2'd2) |-> ##2 pv[3:0] == 4'h1 && OTP_TRIAL_MODE && !FUNC_REGS_ALLOWED)
    else $error("trial pattern wrong");
  a_user_keeps: assert property (s_apply(2'd0) |=> $stable(pv) [*2])
    else $error("user apply moved pins");
  a_apply_only: assert property (
    WR && ADDR == ADDR_MODE && !WDATA[2] |=> $stable(pv) [*2])
    else $error("mode moved without apply");
  a_comm_flags: assert property (
    WR && ADDR == ADDR_COMM |=>
      {I2C_SECURE_WRITE, I2C_CRC_ENABLE, I2C_TARGET_ADDR} == $past(WDATA[8:0]))
    else $error("comm flags wrong");
  // a pin write in the cycle after an apply is refused by the controller
  a_pin_write: assert property (
    WR && ADDR == ADDR_PINS && !$past(WR && ADDR == ADDR_MODE && WDATA[2])
      |=> pv == $past(WDATA[6:0]))
    else $error("pin write wrong");
  a_pulse_level: assert property (
    WR && ADDR == ADDR_PULSE |=> POWER_ON_PIN == $past(WDATA[0]))
    else $error("pulse level wrong");
  a_read_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data without read");
endmodule : pin_mode_ctrl_sva
bind pin_mode_ctrl pin_mode_ctrl_sva i_sva (
  .CORE_CLK                  (CORE_CLK),
  .RST_N                     (RST_N),
  .WR                        (WR),
  .RD                        (RD),
  .ADDR                      (ADDR),
  .WDATA                     (WDATA),
  .RDATA                     (RDATA),
  .OTP_DEBUG_ENABLE          (OTP_DEBUG_ENABLE),
  .STANDBY_PIN               (STANDBY_PIN),
  .WATCHDOG_INPUT_PIN        (WATCHDOG_INPUT_PIN),
  .POWER_ON_PIN              (POWER_ON_PIN),
  .AUX_REGULATOR_ENABLE_PIN  (AUX_REGULATOR_ENABLE_PIN),
  .EXTERNAL_INTERRUPT_INPUT  (EXTERNAL_INTERRUPT_INPUT),
  .OUTPUT_VOLTAGE_SELECT_PIN (OUTPUT_VOLTAGE_SELECT_PIN),
  .I2C_CRC_ENABLE            (I2C_CRC_ENABLE),
  .I2C_SECURE_WRITE          (I2C_SECURE_WRITE),
  .I2C_TARGET_ADDR           (I2C_TARGET_ADDR),
  .OTP_TRIAL_MODE            (OTP_TRIAL_MODE),
  .FUNC_REGS_ALLOWED         (FUNC_REGS_ALLOWED)
);
`default_nettype wire

// >>> tb/tb_pin_mode_ctrl.sv
/* self-checking bench of the pin and mode controller with a chip model on its pins.
   assumes read data stand only in the cycle after the read strobe. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module tb_pin_mode_ctrl;
  import pin_ctrl_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, crc, sec, trial, func, pw, qt, mo;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h3B26EE16, v;
  logic [6:0]  i2c_addr, exp_p;
  logic [1:0]  m, cur_m = 2'd0;
  wire logic [6:0] pins;
  int          num_errors = 0, num_checks = 0, presses, e0, n, ew = 0, wdog;
  logic        irq, ei = 1'b0, lw = 1'b0;
  initial forever #10 clk = ~clk;
  pin_mode_ctrl i_pin_mode_ctrl (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .OTP_DEBUG_ENABLE(pins[0]), .STANDBY_PIN(pins[1]),
    .WATCHDOG_INPUT_PIN(pins[2]), .POWER_ON_PIN(pins[3]), .AUX_REGULATOR_ENABLE_PIN(pins[4]),
    .EXTERNAL_INTERRUPT_INPUT(pins[5]), .OUTPUT_VOLTAGE_SELECT_PIN(pins[6]),
    .I2C_TARGET_ADDR(i2c_addr), .I2C_CRC_ENABLE(crc), .I2C_SECURE_WRITE(sec),
    .OTP_TRIAL_MODE(trial), .FUNC_REGS_ALLOWED(func));
  pmic_model i_pmic_model (.clk(clk), .pins(pins), .powered(pw), .quiet(qt),
    .mirrors_open(mo), .presses(presses), .irq_seen(irq), .wdog_events(wdog));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [6:0] mode_pins(input logic [1:0] md, input logic [6:0] p);
    case (md)
      2'd1: return {p[6:4], 4'h8};
      2'd2: return {p[6:4], 4'h1};
      default: return p;
    endcase
  endfunction : mode_pins
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd_chk
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("addr", I2C_ADDR_RESET, i2c_addr)
    rd_chk(ADDR_COMM, {25'h0, I2C_ADDR_RESET});
    rd_chk(ADDR_DIV, {16'h0, DIV_RESET});
    rd_chk(4'hF, 32'h0);
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      m = 2'(k % 3);
      wr_reg(ADDR_PINS, v);
      @(posedge clk); #1;
      `CHK("pins", v[6:0], pins)
      `CHK("mirror", v[0], mo)
      if (v[2] && !lw) ew++;
      lw = v[2];
      ei |= v[5];
      wr_reg(ADDR_COMM, v >> 8);
      @(posedge clk); #1;
      `CHK("comm", v[16:8], {sec, crc, i2c_addr})
      exp_p = pins;
      if (k % 4 != 3) cur_m = m;
      wr_reg(ADDR_MODE, {29'h0, k % 4 != 3, m});
      repeat (2) @(posedge clk); #1;
      exp_p = mode_pins(k % 4 != 3 ? m : 2'd0, exp_p);
      lw = exp_p[2];
      `CHK("mode", exp_p, pins)
      `CHK("gate", {cur_m == 2, cur_m != 2}, {trial, func})
      if (k % 4 != 3 && m != 0) `CHK("target", {m == 1, m == 2}, {pw, qt})
      rd_chk(ADDR_MODE, {30'h0, cur_m});
    end
    wr_reg(ADDR_MODE, 32'h5);
    wr_reg(ADDR_DIV, 32'h0);
    repeat (3) @(posedge clk); #1;
    // pin write right behind an apply must be dropped and flagged
    exp_p = mode_pins(2'd1, pins);
    @(posedge clk);
    addr <= ADDR_MODE; wdata <= 32'h5; wr <= 1'b1;
    @(posedge clk);
    addr <= ADDR_PINS; wdata <= 32'h7F;
    @(posedge clk);
    wr <= 1'b0;
    rd_chk(ADDR_STATUS, 32'h10);
    `CHK("refused", exp_p, pins)
    wr_reg(ADDR_STATUS, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0);
    e0 = presses;
    wr_reg(ADDR_PULSE, 32'h0);
    @(posedge clk); #1;
    `CHK("press", 1'b0, pins[3])
    for (n = 0; n < 200 && !pins[3]; n++) begin
      @(posedge clk); #1;
    end
    `CHK("irq", ei, irq)
    `CHK("wdog", ew, wdog)
    if (n == 200) begin
      num_errors++;
    end else begin
      @(posedge clk); #1;
      `CHK("width", 1'b1, n == PULSE_CYCLES - 1)
      `CHK("presses", e0 + 1, presses)
    end
    complete_run();
  end
endmodule : tb_pin_mode_ctrl
`undef CHK
`default_nettype wire
